// >>> design/vip_top.sv
// Vectored interrupt prioritizer: pending flags, arbitration, vector fetch
// Summary of operation
// - Twenty vectors are served, fed by twelve pin sources and eight on-chip sources.
// - Eight pins trigger on a selectable rising or falling edge, four on both edges.
// - Each source gets its own level of three, used when picking the request to present.
// - A watchdog time-out can be taken as an interrupt source instead of a reset.
// - Pending requests are arbitrated and the winner makes the core enter its service routine.
// - Each 16-bit vector is read from program memory, upper byte at the even address first.
// - The port C pin 0 dual-edge source is lowest at 0036H, and 0038H is never issued.
// - In polled handling no request is presented and flags stay readable.
// - One master enable blocks all delivery when clear and permits it when set.
// - Sources absent from a package variant, and the ADC source when absent, are removed.
// - In watchdog interrupt mode a time-out raises a request taken only while enabled.
module vip_top
    import vip_pkg::*;
#(
    parameter logic [NUM_PIN-1:0] PIN_PRESENT = '1,
    parameter bit HAS_ADC = 1'b1,
    parameter int ADC_VEC = ADC_VEC_DEFAULT
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [NUM_PIN-1:0] gpio_pin,
    input wire logic [NUM_SEL_PIN-1:0] gpio_edge_rise,
    input wire logic [NUM_PERIPH-1:0] periph_evt,
    input wire logic wdt_timeout,
    input wire logic watchdog_timeout_action,
    input wire logic [NUM_VEC-1:0][LVL_W-1:0] src_level,
    input wire logic [NUM_VEC-1:0] pend_clr,
    input wire logic polled_mode,
    input wire logic enable_irq_instruction,
    input wire logic return_from_irq_instruction,
    input wire logic disable_irq_instruction,
    input wire logic irq_ack,
    output logic irq_req,
    output logic [IDX_W-1:0] irq_vec_idx,
    output logic [LVL_W-1:0] irq_level,
    output logic pm_rd,
    output logic [15:0] pm_addr,
    input wire logic [7:0] pm_rdata,
    output logic [15:0] vec_data,
    output logic vec_valid,
    output logic [NUM_VEC-1:0] pend_flags,
    output logic master_irq_enable,
    output logic wdt_reset_req
);
    vip_pin_if #(.N(NUM_PIN)) pif ();

    logic [NUM_VEC-1:0] src_present;
    logic [NUM_VEC-1:0] src_evt;
    logic [NUM_VEC-1:0] pend;
    logic [NUM_VEC-1:0] ack_clr;
    logic win_any;
    logic [IDX_W-1:0] win_idx;
    logic [LVL_W-1:0] win_lvl;
    logic take;
    vip_fetch_t state;
    vip_fetch_t next_state;
    logic [15:0] vec_q;
    logic vec_valid_q;
    logic wdt_rst_q;

    // Pin edge detection: low eight selectable, upper four on both edges
    assign pif.pin_raw = gpio_pin;
    assign pif.rise_sel = {{NUM_DUAL_PIN{1'b0}}, gpio_edge_rise};
    assign pif.both_sel = {{NUM_DUAL_PIN{1'b1}}, {NUM_SEL_PIN{1'b0}}};

    vip_edge_detect #(.N(NUM_PIN)) u_edge (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .pif(pif)
    );

    // Sources missing from this variant are masked out
    always_comb
    begin
        src_present = {PIN_PRESENT, {NUM_PERIPH{1'b1}}};
        if (!HAS_ADC)
            src_present[ADC_VEC] = 1'b0;
    end

    // Event map: on-chip sources first, then pins; watchdog shares a vector
    always_comb
    begin
        src_evt = {pif.evt, periph_evt};
        if (wdt_timeout && watchdog_timeout_action == WDT_ACT_IRQ)
            src_evt[WDT_VEC] = 1'b1;
        src_evt = src_evt & src_present;
    end

    // Watchdog reset mode: time-out asks for a system reset instead
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            wdt_rst_q <= 1'b0;
        else if (ce)
            wdt_rst_q <= wdt_timeout && watchdog_timeout_action != WDT_ACT_IRQ;
    end

    // Taking a request: presented, acknowledged and sequencer free
    assign take = irq_req && irq_ack;

    always_comb
    begin
        ack_clr = '0;
        if (take)
            ack_clr[win_idx] = 1'b1;
    end

    // Pending flags: set wins over acknowledge or software clear
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pend <= '0;
        else if (ce)
            pend <= (pend & ~(pend_clr | ack_clr)) | src_evt;
    end

    // Master enable: set by enable and return instructions, cleared on entry
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            master_irq_enable <= 1'b0;
        else if (ce)
        begin
            if (enable_irq_instruction || return_from_irq_instruction)
                master_irq_enable <= 1'b1;
            else if (disable_irq_instruction || take)
                master_irq_enable <= 1'b0;
        end
    end

    // Arbiter: highest level wins, lower index wins a tie
    always_comb
    begin
        win_any = 1'b0;
        win_idx = '0;
        win_lvl = LVL_OFF;
        for (int i = 0; i < NUM_VEC; i++)
        begin
            if (pend[i] && src_level[i] != LVL_OFF && src_level[i] > win_lvl)
            begin
                win_any = 1'b1;
                win_idx = IDX_W'(i);
                win_lvl = src_level[i];
            end
        end
    end

    // Presented only when enabled, vectored handling and fetcher idle
    assign irq_req = win_any && master_irq_enable && !polled_mode
        && state == VIP_IDLE;
    assign irq_vec_idx = win_idx;
    assign irq_level = win_lvl;

    // Vector fetch sequencer
    always_comb
    begin
        next_state = state;
        unique case (state)
            VIP_IDLE:
                if (take)
                    next_state = VIP_RD_HI;
            VIP_RD_HI:
                next_state = VIP_RD_LO;
            VIP_RD_LO:
                next_state = VIP_WAIT_LO;
            VIP_WAIT_LO:
                next_state = VIP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            state <= VIP_IDLE;
        else if (ce)
            state <= next_state;
    end

    // Read strobe while an address is on the bus
    assign pm_rd = state == VIP_RD_HI || state == VIP_RD_LO;

    // Vector address: even byte first, then the odd byte
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pm_addr <= VEC_BASE;
        else if (ce)
        begin
            if (take)
                pm_addr <= VEC_BASE + {10'h000, win_idx, 1'b0};
            else if (state == VIP_RD_HI)
                pm_addr <= pm_addr | VEC_ODD;
        end
    end

    // Byte assembly: upper byte from even address, lower from odd
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            vec_q <= '0;
            vec_valid_q <= 1'b0;
        end
        else if (ce)
        begin
            vec_valid_q <= state == VIP_WAIT_LO;
            if (state == VIP_RD_LO)
                vec_q[15:8] <= pm_rdata;
            if (state == VIP_WAIT_LO)
                vec_q[7:0] <= pm_rdata;
        end
    end

    assign vec_data = vec_q;
    assign vec_valid = vec_valid_q;
    assign pend_flags = pend;
    assign wdt_reset_req = wdt_rst_q;
endmodule

// >>> common/vip_pkg.sv
// Constants and types shared by the interrupt prioritizer
package vip_pkg;
    localparam int NUM_VEC = 20;
    localparam int NUM_PERIPH = 8;
    localparam int NUM_SEL_PIN = 8;
    localparam int NUM_DUAL_PIN = 4;
    localparam int NUM_PIN = NUM_SEL_PIN + NUM_DUAL_PIN;
    localparam int IDX_W = 5;
    localparam int LVL_W = 2;
    // Vector table: index 0 highest fixed priority, index 19 lowest
    localparam logic [15:0] VEC_BASE = 16'h0010;
    localparam logic [15:0] VEC_LOWEST = 16'h0036;
    localparam logic [15:0] VEC_RESERVED = 16'h0038;
    localparam logic [15:0] VEC_ODD = 16'h0001;
    // Source index layout
    localparam int PERIPH_FIRST = 0;
    localparam int PIN_FIRST = NUM_PERIPH;
    localparam int WDT_VEC = 0;
    localparam int ADC_VEC_DEFAULT = 5;
    // Priority level encodings
    localparam logic [LVL_W-1:0] LVL_OFF = 2'h0;
    // Watchdog action option value that selects interrupt mode
    localparam logic WDT_ACT_IRQ = 1'b0;
    // Vector fetch sequencer states
    typedef enum logic [1:0] {
        VIP_IDLE,
        VIP_RD_HI,
        VIP_RD_LO,
        VIP_WAIT_LO
    } vip_fetch_t;
endpackage

// >>> common/vip_pin_if.sv
// Carrier between the pin edge detector and the prioritizer core
interface vip_pin_if #(parameter int N = 12);
    logic [N-1:0] pin_raw;
    logic [N-1:0] rise_sel;
    logic [N-1:0] both_sel;
    logic [N-1:0] evt;
    modport det (input pin_raw, input rise_sel, input both_sel, output evt);
    modport core (output pin_raw, output rise_sel, output both_sel, input evt);
endinterface

// >>> design/vip_edge_detect.sv
// Pin synchroniser and edge detector for GPIO interrupt inputs
module vip_edge_detect
    import vip_pkg::*;
#(
    parameter int N = 12
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    vip_pin_if.det pif
);
    logic [N-1:0] sync_a;
    logic [N-1:0] sync_b;
    logic [N-1:0] last;
    logic [N-1:0] evt_q;
    logic [N-1:0] next_evt;
    logic fill_a;
    logic fill_b;
    logic hist_ok;

    // Two-stage synchroniser, then a history stage for edge compare
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sync_a <= '0;
            sync_b <= '0;
            last <= '0;
        end
        else if (ce)
        begin
            sync_a <= pif.pin_raw;
            sync_b <= sync_a;
            last <= sync_b;
        end
    end

    // Fill tracking: history holds real pin levels only after three edges
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            fill_a <= 1'b0;
            fill_b <= 1'b0;
            hist_ok <= 1'b0;
        end
        else if (ce)
        begin
            fill_a <= 1'b1;
            fill_b <= fill_a;
            hist_ok <= fill_b;
        end
    end

    // Edge select per pin: both edges, rising or falling
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_edge
            always_comb
            begin
                if (pif.both_sel[g])
                    next_evt[g] = sync_b[g] ^ last[g];
                else if (pif.rise_sel[g])
                    next_evt[g] = sync_b[g] & ~last[g];
                else
                    next_evt[g] = ~sync_b[g] & last[g];
            end
        end
    endgenerate

    // Registered one-cycle event pulses, none while history is still unfilled
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            evt_q <= '0;
        else if (ce)
            evt_q <= hist_ok ? next_evt : '0; // Avoids a false edge from pins idling high
    end

    assign pif.evt = evt_q;
endmodule

// >>> tb/vip_top_props.sv
// Port assertions for the interrupt prioritizer
module vip_top_props
    import vip_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wdt_timeout,
    input wire logic watchdog_timeout_action,
    input wire logic [NUM_VEC-1:0][LVL_W-1:0] src_level,
    input wire logic polled_mode,
    input wire logic irq_ack,
    input wire logic irq_req,
    input wire logic [IDX_W-1:0] irq_vec_idx,
    input wire logic [LVL_W-1:0] irq_level,
    input wire logic pm_rd,
    input wire logic [15:0] pm_addr,
    input wire logic vec_valid,
    input wire logic [NUM_VEC-1:0] pend_flags,
    input wire logic master_irq_enable,
    input wire logic wdt_reset_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Fetch sequence after an accepted request
    ack_fetch_a: assert property (ce && irq_req && irq_ack |=> pm_rd
        && pm_addr == VEC_BASE + {$past(irq_vec_idx), 1'b0}) else $error("bad fetch");
    hi_then_lo_a: assert property (ce && pm_rd && !pm_addr[0] |=> pm_rd
        && pm_addr == ($past(pm_addr) | VEC_ODD)) else $error("bad byte order");
    vec_time_a: assert property (ce && irq_req && irq_ack |-> ##4 vec_valid)
        else $error("vector late");
    addr_range_a: assert property (pm_rd |-> pm_addr <= VEC_LOWEST + VEC_ODD)
        else $error("reserved fetch");
    // Presentation rules
    gate_a: assert property (irq_req |-> master_irq_enable && !polled_mode)
        else $error("ungated request");
    pick_level_a: assert property (irq_req |-> pend_flags[irq_vec_idx]
        && irq_level == src_level[irq_vec_idx] && irq_level != LVL_OFF) else $error("bad pick");
    // Watchdog handling
    wdt_reset_a: assert property (ce && wdt_timeout && watchdog_timeout_action != WDT_ACT_IRQ
        |=> wdt_reset_req) else $error("no reset");
    wdt_irq_a: assert property (ce && wdt_timeout && watchdog_timeout_action == WDT_ACT_IRQ
        |=> pend_flags[WDT_VEC] && !wdt_reset_req) else $error("no wdt irq");
    cover property (ce && irq_req && irq_ack);
    cover property (pm_rd && pm_addr == VEC_LOWEST);
    cover property (wdt_reset_req);
endmodule

bind vip_top vip_top_props vip_top_props_inst (.sys_clk, .rst, .ce, .wdt_timeout,
    .watchdog_timeout_action, .src_level, .polled_mode, .irq_ack, .irq_req, .irq_vec_idx,
    .irq_level, .pm_rd, .pm_addr, .vec_valid, .pend_flags, .master_irq_enable, .wdt_reset_req);

// >>> tb/vip_core_model.sv
// Processor core model: takes requests and serves program memory bytes
module vip_core_model
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ack_en,
    input wire logic irq_req,
    input wire logic pm_rd,
    input wire logic [15:0] pm_addr,
    output logic irq_ack,
    output logic [7:0] pm_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // One-cycle acknowledge while allowed
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            irq_ack <= 1'b0;
        else
            irq_ack <= ack_en && irq_req && !irq_ack;
    end
    // Byte one cycle after a read, else garbage
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pm_rdata <= 8'h00;
        else if (pm_rd)
            pm_rdata <= pm_addr[7:0] ^ 8'h5A;
        else
            pm_rdata <= ~pm_rdata;
    end
endmodule

// >>> tb/test_vectored_interrupt_prioritizer.sv
// Self-checking bench for the interrupt prioritizer
module test_vectored_interrupt_prioritizer
    import vip_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [NUM_PIN-1:0] gpio_pin = 12'h001;
    logic [NUM_SEL_PIN-1:0] gpio_edge_rise = 8'h00;
    logic [NUM_PERIPH-1:0] periph_evt = 8'h00;
    logic wdt_timeout = 1'b0;
    logic watchdog_timeout_action = 1'b1;
    logic [NUM_VEC-1:0][LVL_W-1:0] src_level = '0;
    logic [NUM_VEC-1:0] pend_clr = '0;
    logic polled_mode = 1'b0;
    logic enable_irq_instruction = 1'b0;
    logic return_from_irq_instruction = 1'b0;
    logic disable_irq_instruction = 1'b0;
    logic ack_en = 1'b0;
    logic irq_ack, irq_req, pm_rd, vec_valid, master_irq_enable, wdt_reset_req;
    logic [IDX_W-1:0] irq_vec_idx;
    logic [LVL_W-1:0] irq_level;
    logic [15:0] pm_addr, vec_data;
    logic [7:0] pm_rdata;
    logic [NUM_VEC-1:0] pend_flags;
    int num_errors = 0;
    int compares = 0;
    vip_top vip_top_inst (.sys_clk, .rst, .ce, .gpio_pin, .gpio_edge_rise, .periph_evt,
        .wdt_timeout, .watchdog_timeout_action, .src_level, .pend_clr, .polled_mode,
        .enable_irq_instruction, .return_from_irq_instruction, .disable_irq_instruction,
        .irq_ack, .irq_req, .irq_vec_idx, .irq_level, .pm_rd, .pm_addr, .pm_rdata,
        .vec_data, .vec_valid, .pend_flags, .master_irq_enable, .wdt_reset_req);
    vip_core_model vip_core_model_inst (.sys_clk, .rst, .ack_en, .irq_req, .pm_rd,
        .pm_addr, .irq_ack, .pm_rdata);
    // 100 MHz clock
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (num_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Strobes: enable, return, disable
    task automatic instr(input logic [2:0] s);
        @(posedge sys_clk);
        {enable_irq_instruction, return_from_irq_instruction, disable_irq_instruction} <= s;
        @(posedge sys_clk);
        {enable_irq_instruction, return_from_irq_instruction, disable_irq_instruction} <= 3'h0;
        #1;
    endtask
    task automatic evt(input logic [7:0] p);
        @(posedge sys_clk);
        periph_evt <= p;
        @(posedge sys_clk);
        periph_evt <= 8'h00;
        #1;
    endtask
    task automatic wdt(input logic act);
        @(posedge sys_clk);
        watchdog_timeout_action <= act;
        wdt_timeout <= 1'b1;
        @(posedge sys_clk);
        wdt_timeout <= 1'b0;
        #1;
    endtask
    task automatic clear_all;
        @(posedge sys_clk);
        pend_clr <= '1;
        @(posedge sys_clk);
        pend_clr <= '0;
        #1;
    endtask
    // Let the core take a request and check the fetched vector
    task automatic serve(input int idx);
        logic [15:0] a;
        a = VEC_BASE + 16'(2 * idx);
        @(posedge sys_clk);
        ack_en <= 1'b1;
        for (int i = 0; i < 40 && vec_valid !== 1'b1; i++)
            step(1);
        if (vec_valid !== 1'b1)
        begin
            num_errors++;
            close_out;
        end
        else
        begin
            check(vec_data, {a[7:0] ^ 8'h5A, (a[7:0] | 8'h01) ^ 8'h5A});
            @(posedge sys_clk);
            ack_en <= 1'b0;
            #1;
        end
    endtask
    task automatic t_vector;
        @(posedge sys_clk);
        src_level <= {NUM_VEC{2'h1}};
        instr(3'h4);
        evt(8'h04);
        check(irq_vec_idx, 5'h02);
        serve(2);
        check(master_irq_enable, 1'b0);
        check(pend_flags, 20'h00000);
        instr(3'h2);
        check(master_irq_enable, 1'b1);
    endtask
    task automatic t_prio;
        @(posedge sys_clk);
        src_level[7] <= 2'h3;
        evt(8'h82);
        check(irq_vec_idx, 5'h07);
        check(irq_level, 2'h3);
        @(posedge sys_clk);
        src_level[7] <= 2'h1;
        step(1);
        check(irq_vec_idx, 5'h01);
        @(posedge sys_clk);
        src_level[1] <= LVL_OFF;
        step(1);
        check(irq_vec_idx, 5'h07);
        clear_all;
        check(pend_flags, 20'h00000);
        @(posedge sys_clk);
        src_level[1] <= 2'h1;
    endtask
    task automatic t_pins;
        @(posedge sys_clk);
        gpio_pin <= 12'h802;
        gpio_edge_rise <= 8'h02;
        step(6);
        check(pend_flags, 20'h80300);
        @(posedge sys_clk);
        pend_clr <= 20'h00300;
        @(posedge sys_clk);
        pend_clr <= '0;
        serve(19);
        @(posedge sys_clk);
        gpio_pin <= 12'h002;
        step(6);
        check(pend_flags, 20'h80000);
        clear_all;
        instr(3'h2);
    endtask
    task automatic t_polled;
        @(posedge sys_clk);
        polled_mode <= 1'b1;
        evt(8'h01);
        check(irq_req, 1'b0);
        check(pend_flags, 20'h00001);
        @(posedge sys_clk);
        polled_mode <= 1'b0;
        step(1);
        check(irq_req, 1'b1);
        clear_all;
    endtask
    task automatic t_wdt;
        wdt(1'b1);
        check(wdt_reset_req, 1'b1);
        check(pend_flags, 20'h00000);
        wdt(WDT_ACT_IRQ);
        check(pend_flags, 20'h00001);
        check(wdt_reset_req, 1'b0);
        instr(3'h1);
        check(irq_req, 1'b0);
        clear_all;
    endtask
    // Clock enable low: a clear strobe is not taken while frozen
    task automatic t_ce;
        evt(8'h08);
        @(posedge sys_clk);
        ce <= 1'b0;
        clear_all;
        check(pend_flags, 20'h00008);
        @(posedge sys_clk);
        ce <= 1'b1;
        clear_all;
        check(pend_flags, 20'h00000);
    endtask
    // Reset in mid-run with a request presented, then no false pin edge
    task automatic t_reset;
        instr(3'h4);
        evt(8'h10);
        @(posedge sys_clk);
        rst <= 1'b1;
        step(2);
        check(pend_flags, 20'h00000);
        check(master_irq_enable, 1'b0);
        check(pm_addr, VEC_BASE);
        @(posedge sys_clk);
        rst <= 1'b0;
        evt(8'h10);
        check(pend_flags, 20'h00010);
        check(irq_req, 1'b0);
        step(3);
        check(pend_flags, 20'h00010);
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_vector;
        t_prio;
        t_pins;
        t_polled;
        t_wdt;
        t_ce;
        t_reset;
        close_out;
    end
endmodule
